// file: flash_cmd_pkg.sv
package flash_cmd_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_STATUS = 6'h00;
  localparam logic [5:0] IDX_LOCK = 6'h01;
  localparam logic [5:0] IDX_CMD_INDEX = 6'h02;
  localparam logic [5:0] IDX_CMD_OBJECT = 6'h03;
  localparam logic [5:0] IDX_CONFIG = 6'h04;
  localparam logic [5:0] IDX_PARTITION = 6'h05;
  localparam logic [5:0] IDX_MARGIN = 6'h06;

  // Status register bit positions.
  localparam int COMMAND_COMPLETE_FLAG_BIT = 7;
  localparam int ACCESS_ERROR_FLAG_BIT = 5;
  localparam int PROTECTION_VIOLATION_FLAG_BIT = 4;
  localparam int VREAD_BIT = 1;
  localparam int VUNCORR_BIT = 0;

  // Configuration register bit positions.
  localparam int SPECIAL_BIT = 0;
  localparam int LOADFIELD_BIT = 1;
  localparam int KEYUNLOCK_BIT = 2;

  // Command opcodes; program and user margin codes are arbitrary defaults.
  localparam logic [7:0] OP_QUERY = 8'h15;
  localparam logic [7:0] OP_PROGRAM = 8'h11;
  localparam logic [7:0] OP_ERASE = 8'h12;
  localparam logic [7:0] OP_USER_MARGIN = 8'h0D;
  localparam logic [7:0] OP_FIELD_MARGIN = 8'h0E;

  // Command index figures checked at launch, and the query result slots.
  localparam logic [2:0] CIX_QUERY = 3'h0;
  localparam logic [2:0] CIX_ONE = 3'h1;
  localparam logic [2:0] CIX_PROG_MIN = 3'h2;
  localparam logic [2:0] CIX_PROG_MAX = 3'h5;
  localparam logic [2:0] SLOT_DFLASH_PARTITION_SIZE = 3'h1;
  localparam logic [2:0] SLOT_BUFFER_RAM_PARTITION_SIZE = 3'h2;
  localparam logic [2:0] SLOT_ERASE_TALLY = 3'h3;
  localparam logic [2:0] SLOT_SECTORS = 3'h4;

  // D-Flash geometry and query reset answers.
  localparam logic [6:0] DF_BLOCK = 7'h10;
  localparam logic [16:0] DF_END = 17'h08000;
  localparam logic [15:0] QUERY_UNPART = 16'hFFFF;
  localparam logic [7:0] QUERY_NOCOUNT = 8'h00;

  // Margin levels.
  localparam logic [15:0] MARGIN_NORMAL = 16'h0000;
  localparam logic [15:0] MARGIN_USER1 = 16'h0001;

  // Lock register fields and values.
  localparam logic [7:0] LOCK_ALL_SET = 8'hFF;
  localparam logic [1:0] BACKDOOR_KEY_ENABLE_ON = 2'b10;
  localparam logic [1:0] SEC_UNLOCKED = 2'b10;

  // Command execution time.
  localparam int CLK_NS = 100;
  localparam int EXEC_NS = 1000;
  localparam int EXEC_CYC = (EXEC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] EXEC_LAST = 8'(EXEC_CYC - 1);

  typedef enum logic [0:0] {ST_IDLE, ST_EXEC} seq_state_t;

  // Configuration byte presented by the array during the reset sequence.
  typedef struct packed {
    logic doubleFault;
    logic [7:0] value;
  } cfg_byte_t;

  // One-cycle request to the flash array.
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [6:0] block;
    logic [15:0] addr;
  } array_req_t;

  // Read margin applied to later reads of one block.
  typedef struct packed {
    logic [6:0] block;
    logic [15:0] level;
  } margin_t;

endpackage : flash_cmd_pkg

// file: flash_command_protection.sv
`timescale 1ns/100ps
// How it works
// R01: Query results stored before completion flag sets; the code stores them at the same edge as the flag.
// R02: Query slots: 1 size, 2 buffer, 3 erases, 4 sectors.
// R03: Unpartitioned query returns all-ones and zero counts.
// R04: Program errors if index below 2 or above 5.
// R05: Program errors while load field sequence active.
// R06: Program errors on odd or invalid address.
// R07: Program errors inside or running into partition.
// R08: Verify sets read and uncorrectable status bits.
// R09: Sector erase opcode 0x12 erases then completes.
// R10: User margin errors on index or bad level.
// R11: Field margin only in special mode, applied.
// R12: Level 0 normal, level 1 first user margin.
// R13: Lock register readable, writes have no effect.
// R14: Lock register loaded from configuration byte.
// R15: Double fault at load sets every lock bit.
// R16: Key access enabled only for pattern 10.
// R17: Backdoor unlock forces lock state bits to 10.
// R18: Software keeps reserved bits erased.
// R19: Software programs phrase once, reserved bytes 0xFF.
// R20: Query errors if index is not zero.
// R21: Launch by clearing flag; busy ignores object writes.
module flash_command_protection (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire flash_cmd_pkg::cfg_byte_t cfgByte,
  input wire logic verifyReadErr,
  input wire logic verifyUncorrErr,
  input wire logic [15:0] sectorCounts,
  output flash_cmd_pkg::array_req_t arrayReq,
  output flash_cmd_pkg::margin_t readMargin,
  output logic backdoorKeyEnable,
  output logic busy
);
  import flash_cmd_pkg::*;

  seq_state_t state_reg; // Sequencer state.
  logic [7:0] count_reg; // Execution cycle counter.
  logic [7:0] op_reg; // Opcode of the running command.
  logic command_complete_flag_reg; // Command complete flag.
  logic access_error_flag_reg; // Access error flag.
  logic vRead_reg; // Verify read error status.
  logic vUncorr_reg; // Verify uncorrectable status.
  logic [2:0] cix_reg; // Command index.
  logic [15:0] cmdObj [8]; // Command object words by index.
  logic special_reg; // Special mode selected.
  logic loadField_reg; // Load data field sequence active.
  logic parted_reg; // Partitioning has been done.
  logic [15:0] dflash_partition_size_reg; // D-Flash partition in sectors.
  logic [15:0] buffer_ram_partition_size_reg; // Buffer RAM partition size.
  logic [15:0] tally_reg; // Sector erase count.
  logic [7:0] lock_reg; // Lock register.
  logic loadPending_reg; // Lock load still owed after reset.
  logic ackPending_reg; // Answer given in this cycle.
  logic [31:0] rdata_reg; // Registered read data.
  logic err_reg; // Registered bus error.
  array_req_t req_reg; // Array request pulse.
  margin_t margin_reg; // Applied read margin.

  logic [5:0] idx; // Register index from the address.
  logic access; // Access phase seen, answer not yet given.
  logic mapped; // Address hits a register.
  logic wrEdge; // Write takes effect at this edge.
  logic launch; // Software cleared the complete flag.
  logic cmdErr; // Launch check failed.
  logic [7:0] opcode;
  logic [6:0] blk;
  logic [15:0] addr;
  logic blkOk;
  logic lvlBad;
  logic [16:0] userEnd; // First byte of the emulated partition.
  logic [16:0] endAddr; // Byte after the last programmed word.
  logic [2:0] words;

  assign idx = paddr[7:2];
  assign mapped = (paddr[1:0] == 2'h0) && (idx <= IDX_MARGIN);
  assign access = psel && penable && !ackPending_reg;
  assign wrEdge = psel && penable && ackPending_reg && pwrite && !err_reg;
  assign pready = ackPending_reg;
  assign prdata = rdata_reg;
  assign pslverr = ackPending_reg && err_reg;
  assign arrayReq = req_reg;
  assign readMargin = margin_reg;
  assign busy = (state_reg == ST_EXEC);
  assign backdoorKeyEnable = (lock_reg[7:6] == BACKDOOR_KEY_ENABLE_ON); // R16

  // Launch needs a one written to the flag while it is set, so a write
  // during execution cannot start a second command.
  assign launch = wrEdge && (idx == IDX_STATUS) && pwdata[COMMAND_COMPLETE_FLAG_BIT] &&
                  command_complete_flag_reg; // R21

  assign opcode = cmdObj[0][15:8];
  assign blk = cmdObj[0][6:0];
  assign addr = cmdObj[1];
  assign blkOk = (blk == DF_BLOCK);
  assign lvlBad = (addr > MARGIN_USER1); // R12
  assign words = cix_reg - CIX_ONE;
  // The emulated partition sits above the user sectors of 256 bytes.
  assign userEnd = parted_reg ? {dflash_partition_size_reg[8:0], 8'h00} : DF_END;
  assign endAddr = {1'b0, addr} + {13'h0000, words, 1'b0};

  // Launch checks, one set per opcode; unknown opcodes are refused.
  always_comb begin
    unique case (opcode)
      OP_QUERY: begin
        cmdErr = (cix_reg != CIX_QUERY); // R20
      end
      OP_PROGRAM: begin
        cmdErr = (cix_reg < CIX_PROG_MIN) || (cix_reg > CIX_PROG_MAX) || // R04
                 loadField_reg || // R05
                 !blkOk || addr[0] || // R06
                 ({1'b0, addr} >= userEnd) || (endAddr > userEnd); // R07
      end
      OP_ERASE: begin
        cmdErr = (cix_reg != CIX_ONE) || loadField_reg || !blkOk ||
                 ({1'b0, addr} >= userEnd);
      end
      OP_USER_MARGIN: begin
        cmdErr = (cix_reg != CIX_ONE) || lvlBad || loadField_reg ||
                 !blkOk; // R10
      end
      OP_FIELD_MARGIN: begin
        cmdErr = !special_reg || (cix_reg != CIX_ONE) || lvlBad ||
                 !blkOk; // R11
      end
      default: begin
        cmdErr = 1'b1;
      end
    endcase
  end

  // Bus answer: registered one cycle into the access phase so that read
  // data comes from flip-flops; costs one wait state per transfer.
  always_ff @(posedge clk) begin
    if (rst) begin
      ackPending_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      err_reg <= 1'b0;
    end else begin
      ackPending_reg <= access;
      if (access) begin
        err_reg <= !mapped;
        rdata_reg <= 32'h00000000;
        if (mapped && !pwrite) begin
          unique case (idx)
            IDX_STATUS: begin
              rdata_reg[COMMAND_COMPLETE_FLAG_BIT] <= command_complete_flag_reg;
              rdata_reg[ACCESS_ERROR_FLAG_BIT] <= access_error_flag_reg;
              rdata_reg[PROTECTION_VIOLATION_FLAG_BIT] <= 1'b0;
              rdata_reg[VREAD_BIT] <= vRead_reg;
              rdata_reg[VUNCORR_BIT] <= vUncorr_reg;
            end
            IDX_LOCK: rdata_reg[7:0] <= lock_reg; // R13
            IDX_CMD_INDEX: rdata_reg[2:0] <= cix_reg;
            IDX_CMD_OBJECT: rdata_reg[15:0] <= cmdObj[cix_reg];
            IDX_CONFIG: begin
              rdata_reg[SPECIAL_BIT] <= special_reg;
              rdata_reg[LOADFIELD_BIT] <= loadField_reg;
            end
            IDX_PARTITION: rdata_reg <= {buffer_ram_partition_size_reg, dflash_partition_size_reg};
            IDX_MARGIN: rdata_reg <= {9'h000, margin_reg};
            default: rdata_reg <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // Sequencer: launch, timed execution and completion.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      count_reg <= 8'h00;
      op_reg <= 8'h00;
      command_complete_flag_reg <= 1'b1;
      req_reg <= '0;
    end else begin
      req_reg.valid <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (launch && !cmdErr) begin
            state_reg <= ST_EXEC;
            command_complete_flag_reg <= 1'b0;
            count_reg <= 8'h00;
            op_reg <= opcode;
            req_reg <= '{1'b1, opcode, blk, addr}; // R09
          end
        end
        ST_EXEC: begin
          count_reg <= count_reg + 8'h01;
          if (count_reg == EXEC_LAST) begin
            state_reg <= ST_IDLE;
            command_complete_flag_reg <= 1'b1; // R01 R09 R11
          end
        end
      endcase
    end
  end

  // Error flags. A new error wins over a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      access_error_flag_reg <= 1'b0;
      vRead_reg <= 1'b0;
      vUncorr_reg <= 1'b0;
    end else begin
      if (launch && cmdErr) begin
        access_error_flag_reg <= 1'b1;
      end else if (wrEdge && idx == IDX_STATUS && pwdata[ACCESS_ERROR_FLAG_BIT]) begin
        access_error_flag_reg <= 1'b0;
      end
      if (launch && !cmdErr) begin
        vRead_reg <= 1'b0;
        vUncorr_reg <= 1'b0;
      end else if (busy && op_reg == OP_PROGRAM) begin
        vRead_reg <= vRead_reg | verifyReadErr; // R08
        vUncorr_reg <= vUncorr_reg | verifyUncorrErr; // R08
      end
    end
  end

  // Software settings; all are frozen while a command runs.
  always_ff @(posedge clk) begin
    if (rst) begin
      cix_reg <= 3'h0;
      special_reg <= 1'b0;
      loadField_reg <= 1'b0;
      parted_reg <= 1'b0;
      dflash_partition_size_reg <= QUERY_UNPART;
      buffer_ram_partition_size_reg <= QUERY_UNPART;
    end else if (wrEdge && !busy) begin
      if (idx == IDX_CMD_INDEX) begin
        cix_reg <= pwdata[2:0];
      end
      if (idx == IDX_CONFIG) begin
        special_reg <= pwdata[SPECIAL_BIT];
        loadField_reg <= pwdata[LOADFIELD_BIT];
      end
      if (idx == IDX_PARTITION) begin
        parted_reg <= 1'b1;
        dflash_partition_size_reg <= pwdata[15:0];
        buffer_ram_partition_size_reg <= pwdata[31:16];
      end
    end
  end

  // Command object words: software loads them while idle, and a finished
  // query overwrites its result slots at the same edge as the complete flag rises.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        cmdObj[i] <= 16'h0000;
      end
    end else if (busy && count_reg == EXEC_LAST && op_reg == OP_QUERY) begin
      cmdObj[SLOT_DFLASH_PARTITION_SIZE] <= parted_reg ? dflash_partition_size_reg : QUERY_UNPART; // R02 R03
      cmdObj[SLOT_BUFFER_RAM_PARTITION_SIZE] <= parted_reg ? buffer_ram_partition_size_reg : QUERY_UNPART; // R02 R03
      cmdObj[SLOT_ERASE_TALLY] <= parted_reg ? tally_reg : QUERY_UNPART; // R02 R03
      cmdObj[SLOT_SECTORS] <= parted_reg ? sectorCounts :
                              {QUERY_NOCOUNT, QUERY_NOCOUNT}; // R02 R03
    end else if (wrEdge && !busy && idx == IDX_CMD_OBJECT) begin
      cmdObj[cix_reg] <= pwdata[15:0]; // R21
    end
  end

  // Erase tally and applied margin level.
  always_ff @(posedge clk) begin
    if (rst) begin
      tally_reg <= 16'h0000;
      margin_reg <= '{DF_BLOCK, MARGIN_NORMAL};
    end else if (busy && count_reg == EXEC_LAST) begin
      if (op_reg == OP_ERASE) begin
        tally_reg <= tally_reg + 16'h0001; // R09
      end
      if (op_reg == OP_USER_MARGIN || op_reg == OP_FIELD_MARGIN) begin
        margin_reg <= '{blk, addr}; // R11 R12
      end
    end
  end

  // Lock register: a constant under reset, then the configuration byte is
  // taken at the first edge after release. Bus writes reach it only through the key unlock bit of the configuration register.
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_reg <= LOCK_ALL_SET;
      loadPending_reg <= 1'b1;
    end else if (loadPending_reg) begin
      loadPending_reg <= 1'b0;
      lock_reg <= cfgByte.doubleFault ? LOCK_ALL_SET : cfgByte.value; // R14 R15
    end else if (wrEdge && idx == IDX_CONFIG && pwdata[KEYUNLOCK_BIT] &&
                 backdoorKeyEnable) begin
      lock_reg[1:0] <= SEC_UNLOCKED; // R17
    end
  end

endmodule : flash_command_protection

// file: flash_command_protection_props.sv
`timescale 1ns/100ps
// Watches the bus answer, command launch, margin and lock view.
module flash_command_protection_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire flash_cmd_pkg::array_req_t arrayReq,
  input wire flash_cmd_pkg::margin_t readMargin,
  input wire logic backdoorKeyEnable,
  input wire logic busy
);
  import flash_cmd_pkg::*;
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // An answered read at the lock offset.
  logic lockRead;
  assign lockRead = pready && !pwrite && paddr == 8'h04;
  // One wait state, then a one-cycle answer.
  wait_state_a: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer is not one wait state");
  // Only a status write may start a command.
  launch_cause_a: assert property (
    $rose(busy) |-> $past(pready && pwrite && paddr == 8'h00))
    else $error("command started without a launch write");
  // Execution ends within a fixed window.
  busy_span_a: assert property (
    $rose(busy) |-> busy [*8] ##[1:3] !busy)
    else $error("command execution length wrong");
  // The array request is a single pulse during execution.
  req_pulse_a: assert property (
    arrayReq.valid |-> busy ##1 !arrayReq.valid)
    else $error("array request not a pulse in execution");
  key_view_a: assert property (
    lockRead |-> backdoorKeyEnable == (prdata[7:6] == BACKDOOR_KEY_ENABLE_ON))
    else $error("key enable disagrees with lock bits");
  lock_width_a: assert property (
    lockRead |-> prdata[31:8] == 24'h0 && !pslverr)
    else $error("lock read returned bad upper bits");
  margin_level_a: assert property (
    readMargin.level <= MARGIN_USER1)
    else $error("margin level out of range");
  // The margin moves only through a command.
  margin_cause_a: assert property (
    !$stable(readMargin) |-> $past(busy) || $past(pready && pwrite))
    else $error("margin changed without a command");
  err_pair_a: assert property (
    pslverr |-> pready)
    else $error("error response without ready");
  cover property ($rose(busy));
  cover property (pslverr);
  cover property (readMargin.level == MARGIN_USER1);
endmodule : flash_command_protection_props

// file: flash_command_protection_bench.sv
`timescale 1ns/100ps
module flash_command_protection_bench;
  import flash_cmd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, backdoorKeyEnable, busy, er;
  cfg_byte_t cfgByte = '0;
  logic verifyReadErr = 1'b0;
  logic verifyUncorrErr = 1'b0;
  logic [15:0] sectorCounts = 16'h0305;
  array_req_t arrayReq, lastReq;
  margin_t readMargin;
  logic [31:0] rd, st;
  int badCount = 0;
  int nCompared = 0;
  // Half period of a 100 ns clock.
  always #50 clk = ~clk;
  // Keeps the last array request, since it stands for one cycle only.
  always @(posedge clk) if (arrayReq.valid) lastReq <= arrayReq;
  flash_command_protection uut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfgByte(cfgByte),
    .verifyReadErr(verifyReadErr), .verifyUncorrErr(verifyUncorrErr),
    .sectorCounts(sectorCounts), .arrayReq(arrayReq),
    .readMargin(readMargin), .backdoorKeyEnable(backdoorKeyEnable),
    .busy(busy));
  // Prints the verdict and ends the run.
  task automatic tally_and_finish;
    if (badCount == 0 && nCompared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] e, g);
    nCompared++;
    if (g !== e) begin
      badCount++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One bus transfer; the request holds until ready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      badCount++;
      tally_and_finish();
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // An idle cycle keeps each signal to one assignment per edge.
    @(posedge clk);
  endtask : apb
  // Reset for five cycles with a given configuration byte.
  task automatic restart(input logic df, input logic [7:0] v);
    rst <= 1'b1;
    cfgByte <= '{doubleFault: df, value: v};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : restart
  // Loads words, launches, pokes the index while busy, waits for done.
  task automatic cmd(input logic [2:0] n, input logic [15:0] w0, w1, w2);
    int k;
    apb(1'b1, 8'h00, 32'h20, rd);
    for (int i = 0; i <= n; i++) begin
      apb(1'b1, 8'h08, 32'(i), rd);
      apb(1'b1, 8'h0C, {16'h0, i == 0 ? w0 : (i == 1 ? w1 : w2)}, rd);
    end
    apb(1'b1, 8'h00, 32'h80, rd);
    apb(1'b1, 8'h08, 32'h5, rd);
    k = 0;
    do begin
      apb(1'b0, 8'h00, 32'h0, st);
      k++;
    end while (st[COMMAND_COMPLETE_FLAG_BIT] !== 1'b1 && k < 30);
    if (k >= 30) begin
      badCount++;
      tally_and_finish();
    end
  endtask : cmd
  // Reads one result slot of the object.
  task automatic slot(input logic [2:0] i, input logic [31:0] e);
    apb(1'b1, 8'h08, {29'h0, i}, rd);
    apb(1'b0, 8'h0C, 32'h0, rd);
    chk("slot", e, rd);
  endtask : slot
  // Reset load of every key pattern, write refusal, fault and unlock.
  task automatic lockScenario;
    for (int k = 0; k < 4; k++) begin
      restart(1'b0, {2'(k), 6'h3D});
      apb(1'b0, 8'h04, 32'h0, rd);
      chk("lock", {24'h0, 2'(k), 6'h3D}, rd);
      chk("keyEnable", {31'h0, k == 2}, {31'h0, backdoorKeyEnable});
    end
    apb(1'b1, 8'h04, 32'h0, rd);
    apb(1'b0, 8'h04, 32'h0, rd);
    chk("lockWrite", 32'hFD, rd);
    restart(1'b1, 8'h00);
    apb(1'b0, 8'h04, 32'h0, rd);
    chk("lockFault", 32'hFF, rd);
    chk("keyFault", 32'h0, {31'h0, backdoorKeyEnable});
    restart(1'b0, 8'hBD);
    apb(1'b1, 8'h10, 32'h4, rd);
    apb(1'b0, 8'h04, 32'h0, rd);
    chk("unlock", 32'hBE, rd);
    apb(1'b0, 8'h40, 32'h0, rd);
    chk("slvErr", 32'h1, {31'h0, er});
  endtask : lockScenario
  // Query before and after partitioning, then a sector erase.
  task automatic queryScenario;
    cmd(3'h1, {OP_QUERY, 8'h00}, 16'h0, 16'h0);
    chk("queryIdx", 32'h1, {31'h0, st[ACCESS_ERROR_FLAG_BIT]});
    cmd(3'h0, {OP_QUERY, 8'h00}, 16'h0, 16'h0);
    chk("queryErr", 32'h0, {31'h0, st[ACCESS_ERROR_FLAG_BIT]});
    slot(3'h1, 32'hFFFF);
    slot(3'h2, 32'hFFFF);
    slot(3'h3, 32'hFFFF);
    slot(3'h4, 32'h0);
    apb(1'b1, 8'h14, 32'h0004_0080, rd);
    apb(1'b0, 8'h14, 32'h0, rd);
    chk("partition", 32'h0004_0080, rd);
    cmd(3'h0, {OP_QUERY, 8'h00}, 16'h0, 16'h0);
    slot(3'h1, 32'h0080);
    slot(3'h2, 32'h0004);
    slot(3'h4, 32'h0305);
    cmd(3'h1, {OP_ERASE, 8'h10}, 16'h7000, 16'h0);
    chk("eraseReq", {1'b1, OP_ERASE, 7'h10, 16'h7000}, lastReq);
    apb(1'b0, 8'h08, 32'h0, rd);
    chk("busyIndex", 32'h1, rd);
    // The erase above must show up in the erase tally of a new query.
    cmd(3'h0, {OP_QUERY, 8'h00}, 16'h0, 16'h0);
    slot(3'h3, 32'h1);
  endtask : queryScenario
  // Program refusals, verify flags and an active load sequence.
  task automatic programScenario;
    logic [2:0] ix [6] = '{3'h1, 3'h6, 3'h2, 3'h5, 3'h2, 3'h5};
    logic [15:0] ad [6] = '{16'h2000, 16'h2000, 16'h2001, 16'h7FFA,
      16'h2000, 16'h7FF0};
    for (int k = 0; k < 6; k++) begin
      cmd(ix[k], {OP_PROGRAM, 8'h10}, ad[k], 16'hA5A5);
      chk("progErr", {31'h0, k < 4}, {31'h0, st[ACCESS_ERROR_FLAG_BIT]});
    end
    verifyReadErr <= 1'b1;
    cmd(3'h2, {OP_PROGRAM, 8'h10}, 16'h2000, 16'h5A5A);
    chk("verifyRead", 32'h2, {30'h0, st[1:0]});
    verifyReadErr <= 1'b0;
    verifyUncorrErr <= 1'b1;
    cmd(3'h2, {OP_PROGRAM, 8'h10}, 16'h2000, 16'h5A5A);
    chk("verifyUncorr", 32'h1, {30'h0, st[1:0]});
    verifyUncorrErr <= 1'b0;
    apb(1'b1, 8'h10, 32'h2, rd);
    cmd(3'h2, {OP_PROGRAM, 8'h10}, 16'h2000, 16'h5A5A);
    chk("loadField", 32'h1, {31'h0, st[ACCESS_ERROR_FLAG_BIT]});
    apb(1'b1, 8'h10, 32'h0, rd);
  endtask : programScenario
  // Margin refusals, then field margin in special mode.
  task automatic marginScenario;
    cmd(3'h1, {OP_USER_MARGIN, 8'h10}, 16'h0002, 16'h0);
    chk("userLevel", 32'h1, {31'h0, st[ACCESS_ERROR_FLAG_BIT]});
    cmd(3'h0, {OP_USER_MARGIN, 8'h10}, 16'h0001, 16'h0);
    chk("userIdx", 32'h1, {31'h0, st[ACCESS_ERROR_FLAG_BIT]});
    cmd(3'h1, {OP_FIELD_MARGIN, 8'h10}, MARGIN_USER1, 16'h0);
    chk("fieldMode", 32'h1, {31'h0, st[ACCESS_ERROR_FLAG_BIT]});
    apb(1'b1, 8'h10, 32'h1, rd);
    cmd(3'h1, {OP_FIELD_MARGIN, 8'h10}, MARGIN_USER1, 16'h0);
    chk("fieldSet", {9'h0, 7'h10, MARGIN_USER1}, {9'h0, readMargin});
    cmd(3'h1, {OP_FIELD_MARGIN, 8'h10}, MARGIN_NORMAL, 16'h0);
    chk("fieldNorm", {9'h0, 7'h10, MARGIN_NORMAL}, {9'h0, readMargin});
    // A legal user margin command must pass and show in the margin view.
    cmd(3'h1, {OP_USER_MARGIN, 8'h10}, MARGIN_USER1, 16'h0);
    chk("userSet", 32'h0, {31'h0, st[ACCESS_ERROR_FLAG_BIT]});
    apb(1'b0, 8'h18, 32'h0, rd);
    chk("marginReg", {9'h0, 7'h10, MARGIN_USER1}, rd);
  endtask : marginScenario
  // Main sequence.
  initial begin
    restart(1'b0, 8'hBD);
    lockScenario();
    queryScenario();
    programScenario();
    marginScenario();
    tally_and_finish();
  end
endmodule : flash_command_protection_bench
bind flash_command_protection flash_command_protection_props props (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .arrayReq(arrayReq), .readMargin(readMargin),
  .backdoorKeyEnable(backdoorKeyEnable), .busy(busy));
